// file: logic/bsp_regs.svh
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH

// Word and lane layout
`define BSP_WORD_W      18
`define BSP_LANE_W      9
`define BSP_LANES       2
`define BSP_BURST       4
`define BSP_ADDR_W      22

// Device token stages, counted in link edges after the start edge
`define BSP_WR_FIRST    1
`define BSP_WR_LAST     4
`define BSP_RD_FIRST    4
`define BSP_RD_LAST     7
`define BSP_RD_STAGES   8
`define BSP_WR_STAGES   5

// Controller write and read sequencing counts
`define BSP_WR_CNT_START 3'h1
`define BSP_WR_CNT_DATA  3'h2
`define BSP_WR_CNT_LAST  3'h5
`define BSP_RD_DRAIN     4'h9

`endif

// file: logic/bsp_pkg.sv
`default_nettype none
`include "bsp_regs.svh"

package bsp_pkg;
    typedef logic [`BSP_WORD_W-1:0] bsp_word_t;
    typedef logic [`BSP_LANES-1:0]  bsp_lane_t;
    typedef enum logic [1:0] {
        CLK_PARKED  = 2'h1,
        CLK_RUNNING = 2'h2
    } bsp_clk_state_e;
endpackage : bsp_pkg

`default_nettype wire

// file: logic/bsp_link_if.sv
`default_nettype none
`include "bsp_regs.svh"

interface bsp_link_if #(parameter int ADDR_W = `BSP_ADDR_W);
    logic                  kP;
    logic                  kN;
    logic                  read_port_select_n;
    logic                  write_port_select_n;
    logic [ADDR_W-1:0]     addr;
    bsp_pkg::bsp_word_t    d;
    bsp_pkg::bsp_lane_t    byte_write_select_n;
    bsp_pkg::bsp_word_t    q;
    logic                  qOe;

    modport dev (
        input  kP, kN, read_port_select_n, write_port_select_n, addr, d,
               byte_write_select_n,
        output q, qOe
    );
    modport ctl (
        output kP, kN, read_port_select_n, write_port_select_n, addr, d,
               byte_write_select_n,
        input  q, qOe
    );
endinterface : bsp_link_if

`default_nettype wire

// file: logic/bsp_device.sv
`default_nettype none
`include "bsp_regs.svh"

// Notes on behaviour
// RULE1 - write starts; data on next two cycles
// RULE2 - read data from t+2.5 to t+4
// RULE3 - burst walks start address upward by one
// RULE4 - back-to-back same-kind starts: second discarded
// RULE5 - select used last cycle is don't-care
// RULE6 - data taken and launched on both rises
// RULE7 - both selects high: nothing, outputs off
// RULE8 - stopped clocks keep state; park high
// RULE9 - both lane selects low: whole word
// RULE10 - lane 0 only: low nine bits
// RULE11 - lane 1 only: high nine bits
// RULE12 - both lane selects high: no change
// RULE13 - lane selects apply per data edge
// RULE14 - both selected from idle: read first, alternate
// RULE15 - read after write returns newest data
module bsp_device #(
    parameter int ADDR_W = `BSP_ADDR_W
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   resetn,
    // Status
    output var  logic   rdBusy,
    output var  logic   wrBusy,
    // Memory link
    bsp_link_if.dev     link
);

    if (ADDR_W < 2 || ADDR_W > `BSP_ADDR_W) begin : gCheck
        $error("bsp_device: ADDR_W out of range");
    end

    localparam int DEPTH = 1 << ADDR_W;

    bsp_pkg::bsp_word_t                 mem [DEPTH];
    logic                               kPPrev_r;
    logic                               kNPrev_r;
    logic                               rdPrev_r;
    logic                               wrPrev_r;
    logic [`BSP_RD_STAGES-1:0]          rdTok_r;
    logic [`BSP_WR_STAGES-1:0]          wrTok_r;
    logic [ADDR_W-1:0]                  rdAdr_r [`BSP_RD_STAGES];
    logic [ADDR_W-1:0]                  wrAdr_r [`BSP_WR_STAGES];
    bsp_pkg::bsp_word_t                 q_r;
    logic                               qOe_r;
    logic                               rdBusy_r;
    logic                               wrBusy_r;

    logic                               kRise;
    logic                               kNRise;
    logic                               edgeNow;
    logic                               rdSel;
    logic                               wrSel;
    logic                               startRd;
    logic                               startWr;
    logic                               wrHit;
    logic                               rdHit;
    logic [1:0]                         wrIdx;
    logic [1:0]                         rdIdx;
    logic [ADDR_W-1:0]                  wrBase;
    logic [ADDR_W-1:0]                  rdBase;
    logic [ADDR_W-1:0]                  wrAddrNow;
    logic [ADDR_W-1:0]                  rdAddrNow;
    bsp_pkg::bsp_word_t                 wrWord;
    bsp_pkg::bsp_word_t                 rdWord;
    logic                               fwd;

    // RULE6 - both clock rises
    assign kRise   = link.kP & ~kPPrev_r;
    assign kNRise  = link.kN & ~kNPrev_r;
    // RULE8 - no rise, no change
    assign edgeNow = kRise | kNRise;

    assign rdSel = ~link.read_port_select_n;
    assign wrSel = ~link.write_port_select_n;

    // RULE4 - drop repeated start
    // RULE5 - select ignored after use
    // RULE14 - read wins unless just read
    assign startRd = kRise & rdSel & ~rdPrev_r;
    // RULE1 - write start decode
    assign startWr = kRise & wrSel & ~wrPrev_r & ~startRd;

    // Token stage select for write capture and read launch
    always_comb begin
        wrHit  = 1'b0;
        wrIdx  = 2'h0;
        wrBase = '0;
        rdHit  = 1'b0;
        rdIdx  = 2'h0;
        rdBase = '0;
        for (int s = `BSP_WR_FIRST; s <= `BSP_WR_LAST; s++) begin
            if (wrTok_r[s]) begin
                wrHit  = 1'b1;
                wrIdx  = 2'(s - `BSP_WR_FIRST);
                wrBase = wrAdr_r[s];
            end
        end
        for (int s = `BSP_RD_FIRST; s <= `BSP_RD_LAST; s++) begin
            if (rdTok_r[s]) begin
                rdHit  = 1'b1;
                rdIdx  = 2'(s - `BSP_RD_FIRST);
                rdBase = rdAdr_r[s];
            end
        end
    end

    // RULE3 - sequential burst addresses
    assign wrAddrNow = wrBase + ADDR_W'(wrIdx);
    assign rdAddrNow = rdBase + ADDR_W'(rdIdx);

    // Lane merge against stored word
    always_comb begin
        wrWord = mem[wrAddrNow];
        for (int l = 0; l < `BSP_LANES; l++) begin
            // RULE9 - RULE10 - RULE11 - RULE12 - lane masking
            // RULE13 - selects taken per edge
            if (!link.byte_write_select_n[l]) begin
                wrWord[l*`BSP_LANE_W +: `BSP_LANE_W] =
                    link.d[l*`BSP_LANE_W +: `BSP_LANE_W];
            end
        end
    end

    // RULE15 - forward same-edge write
    assign fwd    = edgeNow & wrHit & (wrAddrNow == rdAddrNow);
    assign rdWord = fwd ? wrWord : mem[rdAddrNow];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            kPPrev_r <= 1'b1;
            kNPrev_r <= 1'b1;
        end else begin
            kPPrev_r <= link.kP;
            kNPrev_r <= link.kN;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdPrev_r <= 1'b0;
            wrPrev_r <= 1'b0;
        end else if (kRise) begin
            rdPrev_r <= startRd;
            wrPrev_r <= startWr;
        end
    end

    // Token pipes advance one stage per link edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdTok_r <= '0;
            wrTok_r <= '0;
        end else if (edgeNow) begin
            rdTok_r <= {rdTok_r[`BSP_RD_STAGES-2:0], startRd};
            wrTok_r <= {wrTok_r[`BSP_WR_STAGES-2:0], startWr};
        end
    end

    always_ff @(posedge clk) begin
        if (edgeNow) begin
            rdAdr_r[0] <= link.addr;
            wrAdr_r[0] <= link.addr;
            for (int i = 1; i < `BSP_RD_STAGES; i++) begin
                rdAdr_r[i] <= rdAdr_r[i-1];
            end
            for (int i = 1; i < `BSP_WR_STAGES; i++) begin
                wrAdr_r[i] <= wrAdr_r[i-1];
            end
        end
    end

    // RULE1 - store one word per edge
    always_ff @(posedge clk) begin
        if (edgeNow && wrHit) begin
            mem[wrAddrNow] <= wrWord;
        end
    end

    // RULE2 - launch words at edges 5 to 8
    // RULE7 - off on first edge without data
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_r   <= '0;
            qOe_r <= 1'b0;
        end else if (edgeNow) begin
            qOe_r <= rdHit;
            if (rdHit) begin
                q_r <= rdWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdBusy_r <= 1'b0;
            wrBusy_r <= 1'b0;
        end else begin
            rdBusy_r <= |rdTok_r;
            wrBusy_r <= |wrTok_r;
        end
    end

    assign link.q   = q_r;
    assign link.qOe = qOe_r;
    assign rdBusy   = rdBusy_r;
    assign wrBusy   = wrBusy_r;

endmodule : bsp_device

`default_nettype wire

// file: logic/bsp_controller.sv
`default_nettype none
`include "bsp_regs.svh"

module bsp_controller #(
    parameter int ADDR_W = `BSP_ADDR_W
) (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            resetn,
    // Clock stop request
    input  wire logic                            linkStop,
    output var  logic                            linkParked,
    // Read request
    input  wire logic                            rdReq,
    input  wire logic [ADDR_W-1:0]               rdAddr,
    output var  logic                            rdAck,
    output var  logic [`BSP_BURST*`BSP_WORD_W-1:0] rdData,
    output var  logic                            rdValid,
    // Write request
    input  wire logic                            wrReq,
    input  wire logic [ADDR_W-1:0]               wrAddr,
    input  wire logic [`BSP_BURST*`BSP_WORD_W-1:0] wrData,
    input  wire logic [`BSP_BURST*`BSP_LANES-1:0]  wrBwN,
    output var  logic                            wrAck,
    // Memory link
    bsp_link_if.ctl                              link
);

    if (ADDR_W < 2 || ADDR_W > `BSP_ADDR_W) begin : gCheck
        $error("bsp_controller: ADDR_W out of range");
    end

    localparam int DW = `BSP_BURST * `BSP_WORD_W;
    localparam int BW = `BSP_BURST * `BSP_LANES;

    bsp_pkg::bsp_clk_state_e        clkState_r;
    logic                           kP_r;
    logic                           kN_r;
    logic                           rpsN_r;
    logic                           wpsN_r;
    logic [ADDR_W-1:0]              addr_r;
    bsp_pkg::bsp_word_t             d_r;
    bsp_pkg::bsp_lane_t             bwsN_r;
    logic                           rdPrev_r;
    logic                           wrPrev_r;
    logic [2:0]                     wrCnt_r;
    logic [3:0]                     rdCnt_r;
    logic [DW-1:0]                  wrBuf_r;
    logic [BW-1:0]                  bwBuf_r;
    logic [DW-1:0]                  rdBuf_r;
    logic [1:0]                     rxCnt_r;
    logic                           rdAck_r;
    logic                           wrAck_r;
    logic                           rdValid_r;
    logic                           parked_r;

    logic                           running;
    logic                           kRiseNext;
    logic                           idle;
    logic                           stopNow;
    logic                           doRd;
    logic                           doWr;
    logic                           wrDataPhase;
    logic [1:0]                     wrWordIdx;

    assign running   = (clkState_r == bsp_pkg::CLK_RUNNING);
    assign kRiseNext = running & ~kP_r;
    assign idle      = (wrCnt_r == 3'h0) & (rdCnt_r == 4'h0);
    assign stopNow   = linkStop & idle;

    // RULE4 - never two reads or writes in a row
    // RULE14 - read first when both wanted
    assign doRd = kRiseNext & ~stopNow & rdReq & ~rdPrev_r;
    assign doWr = kRiseNext & ~stopNow & wrReq & ~wrPrev_r & ~doRd
                & (wrCnt_r == 3'h0);

    assign wrDataPhase = (wrCnt_r >= `BSP_WR_CNT_DATA)
                       & (wrCnt_r <= `BSP_WR_CNT_LAST);
    assign wrWordIdx   = 2'(wrCnt_r - `BSP_WR_CNT_DATA);

    // RULE8 - park both clocks high
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clkState_r <= bsp_pkg::CLK_PARKED;
            kP_r       <= 1'b1;
            kN_r       <= 1'b1;
            parked_r   <= 1'b1;
        end else begin
            case (clkState_r)
                bsp_pkg::CLK_PARKED: begin
                    if (!linkStop) begin
                        kP_r       <= 1'b0;
                        parked_r   <= 1'b0;
                        clkState_r <= bsp_pkg::CLK_RUNNING;
                    end
                end
                bsp_pkg::CLK_RUNNING: begin
                    kP_r <= ~kP_r;
                    kN_r <= kP_r | stopNow;
                    if (kRiseNext && stopNow) begin
                        parked_r   <= 1'b1;
                        clkState_r <= bsp_pkg::CLK_PARKED;
                    end
                end
                default: begin
                    clkState_r <= bsp_pkg::CLK_PARKED;
                end
            endcase
        end
    end

    // RULE1 - selects and address at K rise
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rpsN_r   <= 1'b1;
            wpsN_r   <= 1'b1;
            addr_r   <= '0;
            rdPrev_r <= 1'b0;
            wrPrev_r <= 1'b0;
            rdAck_r  <= 1'b0;
            wrAck_r  <= 1'b0;
        end else begin
            rpsN_r  <= ~doRd;
            wpsN_r  <= ~doWr;
            rdAck_r <= doRd;
            wrAck_r <= doWr;
            if (doRd) begin
                addr_r <= rdAddr;
            end else if (doWr) begin
                addr_r <= wrAddr;
            end
            if (kRiseNext) begin
                rdPrev_r <= doRd;
                wrPrev_r <= doWr;
            end
        end
    end

    // RULE13 - per-word lane selects driven
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrCnt_r <= 3'h0;
            wrBuf_r <= '0;
            bwBuf_r <= '1;
            d_r     <= '0;
            bwsN_r  <= '1;
        end else begin
            if (doWr) begin
                wrCnt_r <= `BSP_WR_CNT_START;
                wrBuf_r <= wrData;
                bwBuf_r <= wrBwN;
            end else if (wrCnt_r == `BSP_WR_CNT_LAST) begin
                wrCnt_r <= 3'h0;
            end else if (wrCnt_r != 3'h0) begin
                wrCnt_r <= wrCnt_r + 3'h1;
            end
            if (wrDataPhase) begin
                d_r    <= wrBuf_r[wrWordIdx*`BSP_WORD_W +: `BSP_WORD_W];
                bwsN_r <= bwBuf_r[wrWordIdx*`BSP_LANES +: `BSP_LANES];
            end else begin
                d_r    <= '0;
                bwsN_r <= '1;
            end
        end
    end

    // RULE2 - collect four words while driven
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdCnt_r   <= 4'h0;
            rxCnt_r   <= 2'h0;
            rdBuf_r   <= '0;
            rdValid_r <= 1'b0;
        end else begin
            if (doRd) begin
                rdCnt_r <= `BSP_RD_DRAIN;
            end else if (rdCnt_r != 4'h0) begin
                rdCnt_r <= rdCnt_r - 4'h1;
            end
            rdValid_r <= 1'b0;
            if (link.qOe) begin
                rdBuf_r[rxCnt_r*`BSP_WORD_W +: `BSP_WORD_W] <= link.q;
                rxCnt_r <= rxCnt_r + 2'h1;
                if (rxCnt_r == 2'h3) begin
                    rdValid_r <= 1'b1;
                end
            end
        end
    end

    assign link.kP                  = kP_r;
    assign link.kN                  = kN_r;
    assign link.read_port_select_n  = rpsN_r;
    assign link.write_port_select_n = wpsN_r;
    assign link.addr                = addr_r;
    assign link.d                   = d_r;
    assign link.byte_write_select_n = bwsN_r;
    assign rdAck                    = rdAck_r;
    assign wrAck                    = wrAck_r;
    assign rdData                   = rdBuf_r;
    assign rdValid                  = rdValid_r;
    assign linkParked               = parked_r;

endmodule : bsp_controller

`default_nettype wire

// file: verif/bsp_link_properties.sv
`default_nettype none
`include "bsp_regs.svh"

module bsp_link_properties #(
    parameter int ADDR_W = `BSP_ADDR_W
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Link signals
    input  wire logic               kP,
    input  wire logic               kN,
    input  wire logic               read_port_select_n,
    input  wire logic               write_port_select_n,
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire bsp_pkg::bsp_word_t d,
    input  wire bsp_pkg::bsp_lane_t byte_write_select_n,
    input  wire bsp_pkg::bsp_word_t q,
    input  wire logic               qOe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic kPPrev_r;
    wire  kRise     = kP && !kPPrev_r;
    wire  readStart = kRise && !read_port_select_n;
    wire  wrStart   = kRise && !write_port_select_n && read_port_select_n;

    always_ff @(posedge clk) begin
        kPPrev_r <= kP;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence sRdBurst;
        ##6 qOe [*4];
    endsequence

    a_read_latency: assert property (
        readStart |-> sRdBurst) else $error("read burst out of place");
    a_read_cause: assert property (
        $rose(qOe) |-> $past(readStart, 6)) else $error("q driven unasked");
    a_burst_four: assert property (
        $fell(qOe) |-> $past(qOe, 4)) else $error("burst too short");
    a_read_spacing: assert property (
        readStart |-> ##2 !readStart) else $error("reads back to back");
    a_write_spacing: assert property (
        wrStart |-> ##2 !wrStart) else $error("writes back to back");
    a_clock_pair: assert property (
        kRise && !kN |=> !kP && kN) else $error("complement rise missing");
    a_clock_high: assert property (
        kP || kN) else $error("both clocks low");
    a_park_idle: assert property (
        kP && kN |-> read_port_select_n && write_port_select_n)
        else $error("select while parked");
    a_lane_idle: assert property (
        wrStart |-> byte_write_select_n == 2'h3)
        else $error("lane selects set at write start");
endmodule : bsp_link_properties

`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
`include "bsp_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int AW = 4;
    localparam int BW = `BSP_BURST*`BSP_WORD_W;

    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    logic               linkStop = 1'b0;
    logic               linkParked;
    logic               rdReq = 1'b0;
    logic [AW-1:0]      rdAddr = '0;
    logic               rdAck;
    logic [BW-1:0]      rdData;
    logic               rdValid;
    logic               wrReq = 1'b0;
    logic [AW-1:0]      wrAddr = '0;
    logic [BW-1:0]      wrData = '0;
    logic [7:0]         wrBwN = 8'hFF;
    logic               wrAck;
    logic               rdBusy;
    logic               wrBusy;
    bsp_pkg::bsp_word_t mem [16];
    int                 errorCnt = 0;
    int                 comparisons = 0;
    int                 cycles = 0;

    bsp_link_if #(.ADDR_W(AW)) link ();

    bsp_device #(.ADDR_W(AW)) bsp_device_inst (
        .clk(clk), .resetn(resetn), .rdBusy(rdBusy), .wrBusy(wrBusy),
        .link(link));

    bsp_controller #(.ADDR_W(AW)) bsp_controller_inst (
        .clk(clk), .resetn(resetn), .linkStop(linkStop),
        .linkParked(linkParked), .rdReq(rdReq), .rdAddr(rdAddr),
        .rdAck(rdAck), .rdData(rdData), .rdValid(rdValid),
        .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
        .wrBwN(wrBwN), .wrAck(wrAck), .link(link));

    bsp_link_properties #(.ADDR_W(AW)) bsp_link_properties_inst (
        .clk(clk), .resetn(resetn), .kP(link.kP), .kN(link.kN),
        .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n),
        .addr(link.addr), .d(link.d),
        .byte_write_select_n(link.byte_write_select_n),
        .q(link.q), .qOe(link.qOe));

    always #50 clk = ~clk;

    task automatic conclude;
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errorCnt++;
            conclude();
        end
    end

    task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic do_write(input logic [AW-1:0] a, input logic [BW-1:0] dat,
                            input logic [7:0] bw);
        logic [AW-1:0] p;
        @(posedge clk);
        wrReq  <= 1'b1;
        wrAddr <= a;
        wrData <= dat;
        wrBwN  <= bw;
        while (wrAck !== 1'b1) @(posedge clk);
        wrReq <= 1'b0;
        repeat (2) @(posedge clk);
        check(BW'(wrBusy), BW'(1'b1));
        for (int j = 0; j < 4; j++) begin
            p = a + AW'(j);
            if (!bw[2*j]) mem[p][8:0] = dat[18*j +: 9];
            if (!bw[2*j+1]) mem[p][17:9] = dat[18*j+9 +: 9];
        end
    endtask : do_write

    task automatic do_read(input logic [AW-1:0] a);
        logic [BW-1:0] exp;
        logic [AW-1:0] p;
        for (int j = 0; j < 4; j++) begin
            p = a + AW'(j);
            exp[18*j +: 18] = mem[p];
        end
        @(posedge clk);
        rdReq  <= 1'b1;
        rdAddr <= a;
        while (rdAck !== 1'b1) @(posedge clk);
        rdReq <= 1'b0;
        repeat (2) @(posedge clk);
        check(BW'(rdBusy), BW'(1'b1));
        while (rdValid !== 1'b1) @(posedge clk);
        check(rdData, exp);
    endtask : do_read

    task automatic t_fill;
        for (int b = 0; b < 4; b++) begin
            do_write(AW'(4*b), {4{18'h2A5 * 18'(b + 1)}} ^
                     {18'h3, 18'h2, 18'h1, 18'h0}, 8'h00);
            do_read(AW'(4*b));
        end
    endtask : t_fill

    task automatic t_lanes;
        do_write(4'h6, {18'h3FFFF, 18'h15555, 18'h2AAAA, 18'h0F0F0},
                 8'h1B);
        do_read(4'h6);
    endtask : t_lanes

    task automatic t_wrap;
        do_write(4'hE, {18'h1E1E1, 18'h2D2D2, 18'h3C3C3, 18'h04B4B},
                 8'h00);
        do_read(4'hE);
        do_read(4'h0);
    endtask : t_wrap

    task automatic t_both;
        fork
            do_read(4'h8);
            do_write(4'h3, {4{18'h13579}}, 8'h00);
            begin
                @(posedge clk iff rdAck);
                @(posedge clk);
                rdReq  <= 1'b1;
                rdAddr <= 4'h3;
                @(posedge clk iff rdAck);
                rdReq  <= 1'b0;
                @(posedge clk iff rdValid);
                @(posedge clk iff rdValid);
                check(rdData, {4{18'h13579}});
            end
        join
        do_write(4'h5, {4{18'h2468A}}, 8'h40);
        do_read(4'h5);
    endtask : t_both

    task automatic t_park;
        @(posedge clk);
        linkStop <= 1'b1;
        while (linkParked !== 1'b1) @(posedge clk);
        repeat (6) begin
            @(posedge clk);
            check(BW'({link.kP, link.kN}), BW'(2'h3));
        end
        check(BW'({rdBusy, wrBusy}), BW'(2'h0));
        linkStop <= 1'b0;
        do_read(4'h4);
    endtask : t_park

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_fill();
        t_lanes();
        t_wrap();
        t_both();
        t_park();
        repeat (12) @(posedge clk);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
